/* File: core/ppms_pkg.sv */
/*
 * Shared constants for the parallel host port: map limits, register layout,
 * state encodings and timing counts for both ends of the link.
 * Assumes one reference clock of 25 MHz on each end.
 */
package ppms_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam int ID_W = 4;
	// Device map: locations at and above MAP_END never complete
	localparam int MAP_SIZE = 232;
	localparam logic [7:0] MAP_END = 8'hE8;
	localparam logic [7:0] CAC_ADDR = 8'h02;
	localparam logic [7:0] CAC_RESET = 8'h00;
	localparam int CAC_ID_LSB = 0;
	localparam int CAC_WIDE_BIT = 4;
	// Read-only output words, little-endian byte pairs
	localparam logic [7:0] OUT_I_ADDR = 8'hE2;
	localparam logic [7:0] OUT_Q_ADDR = 8'hE4;
	localparam logic [7:0] OUT_SS_ADDR = 8'hE6;
	// Port clock edges an internal access takes
	localparam int ACCESS_EDGES = 2;
	// Timing
	localparam int REF_CLK_NS = 40;
	localparam int PORT_CLK_MAX_MHZ = 100;
	localparam int PORT_PERIOD_NS = 320;
	localparam int PORT_HALF_CYC = PORT_PERIOD_NS / (2 * REF_CLK_NS);
	localparam int PORT_HALF_MIN = 3;
	localparam int TIMEOUT_NS = 100000;
	localparam int TIMEOUT_CYC = TIMEOUT_NS / REF_CLK_NS;
	// Host controller registers
	localparam logic [2:0] H_ADDR = 3'h0;
	localparam logic [2:0] H_WDATA = 3'h1;
	localparam logic [2:0] H_CMD = 3'h2;
	localparam logic [2:0] H_STATUS = 3'h3;
	localparam logic [2:0] H_RDATA = 3'h4;
	localparam int CMD_GO = 0;
	localparam int CMD_READ = 1;
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_TIMEOUT = 2;

	typedef enum logic [2:0] {
		PPMS_D_IDLE = 3'b000,
		PPMS_D_BUSY = 3'b001,
		PPMS_D_DONE = 3'b011,
		PPMS_D_SKIP = 3'b010,
		PPMS_D_HANG = 3'b110
	} ppms_dev_state_t;

	typedef enum logic [2:0] {
		PPMS_H_IDLE = 3'b000,
		PPMS_H_SETUP = 3'b001,
		PPMS_H_SELECT = 3'b011,
		PPMS_H_WAIT = 3'b010,
		PPMS_H_END = 3'b110,
		PPMS_H_RELEASE = 3'b111
	} ppms_host_state_t;
endpackage : ppms_pkg

/* File: core/ppms_link_if.sv */
/*
 * Pins between host and device ports.
 * Resolves the shared data bus and the open-drain ready/acknowledge pin.
 */
`timescale 1ns/100ps
interface ppms_link_if;
	logic host_port_clock;
	logic cs_n;
	logic strobe_a_n;
	logic strobe_b_n;
	logic [7:0] addr;
	logic [15:0] host_d;
	logic host_d_oe;
	logic [15:0] dev_d;
	logic dev_d_oe;
	logic ack_oe;
	logic [15:0] data;
	logic transfer_ack_n;

	// Pull-ups on a floating bus
	assign data = dev_d_oe ? dev_d : (host_d_oe ? host_d : 16'hFFFF);
	assign transfer_ack_n = ~ack_oe;

	modport dev(
		input host_port_clock, cs_n, strobe_a_n, strobe_b_n, addr, data,
		output dev_d, dev_d_oe, ack_oe
	);
	modport host(
		output host_port_clock, cs_n, strobe_a_n, strobe_b_n, addr, host_d, host_d_oe,
		input data, transfer_ack_n
	);
endinterface : ppms_link_if

/* File: core/ppms_device.sv */
/*
 * Device end of the parallel host port: register map, output words,
 * split- and combined-strobe protocols, chip-ID filtering.
 * Assumes the host makes the port clock well below ref_clk_i / 6.
 */
// Implementation choice: strobed register access.
// Operation
// (R1) Port works only with select strap low
// (R2) Every register reached by 8-bit address
// (R3) Data width 8 or 16 per control
// (R4) Host supplies slow port clock
// (R5) Strap picks split or combined strobes
// (R6) Split mode samples on port clock rise
// (R7) Split strobes give type, chip select
// (R8) Host drives writes, device drives reads
// (R9) Ready low while access runs
// (R10) Out-of-map address never completes
// (R11) Host write order, wait ready, release
// (R12) Split read: data valid at ready
// (R13) Combined: direction line plus data strobe
// (R14) Acknowledge low at completion, released after
// (R15) Combined write handshake order
// (R16) Combined read: data with acknowledge
// (R17) Chip-ID match needed to complete; writes to the control byte complete without a match
// (R18) Output words readable through port
// (R19) Unused bits read back as stored
// (R20) Mismatch leaves bus and ack released
// (R21) Ready high when idle until release
`timescale 1ns/100ps
module ppms_device #(
	parameter int ACCESS_EDGES = ppms_pkg::ACCESS_EDGES
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	// Link
	ppms_link_if.dev link,
	// Straps and board pins
	input wire logic port_select_strap_i,
	input wire logic strobe_mode_i,
	input wire logic [ppms_pkg::ID_W-1:0] board_id_pins_i,
	// Core output words
	input wire logic [ppms_pkg::DATA_W-1:0] i_word_i,
	input wire logic [ppms_pkg::DATA_W-1:0] q_word_i,
	input wire logic [ppms_pkg::DATA_W-1:0] signal_strength_word_i,
	// Register write notice to the core
	output logic reg_wr_o,
	output logic [ppms_pkg::ADDR_W-1:0] reg_addr_o,
	output logic [ppms_pkg::DATA_W-1:0] reg_wdata_o,
	output logic bus_wide_o
);
	import ppms_pkg::*;

	localparam int SW = 4 + ADDR_W + DATA_W + 2 + ID_W;

	if (ACCESS_EDGES < 1 || ACCESS_EDGES > 15) begin : g_bad_edges
		$error("ACCESS_EDGES must lie in 1..15");
	end

	logic [SW-1:0] meta;
	logic [SW-1:0] sync;
	logic clk_prev;
	logic port_edge;
	logic s_clk;
	logic s_cs_n;
	logic s_a_n;
	logic s_b_n;
	logic [7:0] s_addr;
	logic [15:0] s_data;
	logic s_sel;
	logic s_mode;
	logic [3:0] s_id;
	logic [7:0] mem [MAP_SIZE];
	logic [7:0] cac;
	logic wide;
	logic req;
	logic req_rd;
	logic id_match;
	logic end_cond;
	logic last_edge;
	logic do_access;
	logic [7:0] hi_addr;
	logic [3:0] edge_cnt;
	logic [7:0] acc_addr;
	logic [15:0] acc_data;
	logic acc_rd;
	ppms_dev_state_t state;
	ppms_dev_state_t next_state;

	// Every pin passes two flops; bus lines are stable at the port edge
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			meta <= '1;
			sync <= '1;
			clk_prev <= 1'b1;
		end else begin
			meta <= {link.host_port_clock, link.cs_n, link.strobe_a_n, link.strobe_b_n,
				link.addr, link.data, port_select_strap_i, strobe_mode_i, board_id_pins_i};
			sync <= meta;
			clk_prev <= s_clk;
		end
	end

	assign {s_clk, s_cs_n, s_a_n, s_b_n, s_addr, s_data, s_sel, s_mode, s_id} = sync;
	assign port_edge = s_clk & ~clk_prev; // R4 R6 R13
	assign cac = mem[CAC_ADDR];
	assign wide = cac[CAC_WIDE_BIT]; // R3

	// Split: strobe_a is write, strobe_b is read; combined: a is direction, b is data strobe
	assign req = s_mode ? (~s_cs_n & ~s_b_n) : (~s_cs_n & (~s_a_n | ~s_b_n)); // R5 R7 R13
	assign req_rd = s_mode ? s_a_n : ~s_b_n; // R7 R13
	// Writes to the control byte are always taken so an ID can be assigned
	assign id_match = (cac[CAC_ID_LSB +: ID_W] == s_id) | (~req_rd & (s_addr == CAC_ADDR)); // R17
	assign end_cond = s_cs_n | (s_mode & s_b_n); // R14
	assign last_edge = (edge_cnt == 4'(ACCESS_EDGES - 1));
	assign do_access = (state == PPMS_D_BUSY) & port_edge & last_edge;
	assign hi_addr = acc_addr + 8'h01;

	function automatic logic [7:0] rd_byte(input logic [7:0] a);
		logic [7:0] b;
		b = 8'h00;
		if (a >= MAP_END) begin
			b = 8'h00;
		end else begin
			case (a)
				OUT_I_ADDR: b = i_word_i[7:0]; // R18
				OUT_I_ADDR + 8'h01: b = i_word_i[15:8];
				OUT_Q_ADDR: b = q_word_i[7:0];
				OUT_Q_ADDR + 8'h01: b = q_word_i[15:8];
				OUT_SS_ADDR: b = signal_strength_word_i[7:0];
				OUT_SS_ADDR + 8'h01: b = signal_strength_word_i[15:8];
				default: b = mem[a]; // R2 R19
			endcase
		end
		return b;
	endfunction : rd_byte

	function automatic logic writable(input logic [7:0] a);
		return (a < OUT_I_ADDR);
	endfunction : writable

	always_comb begin
		next_state = state;
		if (s_sel) begin
			next_state = PPMS_D_IDLE; // R1
		end else if (port_edge) begin
			case (state)
				PPMS_D_IDLE: begin
					if (req) begin
						if (s_addr >= MAP_END) begin
							next_state = PPMS_D_HANG; // R10
						end else if (!id_match) begin
							next_state = PPMS_D_SKIP; // R17 R20
						end else begin
							next_state = PPMS_D_BUSY;
						end
					end
				end
				PPMS_D_BUSY: begin
					if (last_edge) begin
						next_state = PPMS_D_DONE;
					end
				end
				PPMS_D_DONE, PPMS_D_SKIP, PPMS_D_HANG: begin
					if (end_cond) begin
						next_state = PPMS_D_IDLE; // R14 R21
					end
				end
				default: next_state = PPMS_D_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state <= PPMS_D_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Access capture and edge counting
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			edge_cnt <= 4'h0;
			acc_addr <= 8'h00;
			acc_data <= 16'h0000;
			acc_rd <= 1'b0;
		end else if (state == PPMS_D_IDLE && next_state == PPMS_D_BUSY) begin
			edge_cnt <= 4'h0;
			acc_addr <= s_addr; // R2
			acc_data <= wide ? s_data : {8'h00, s_data[7:0]}; // R3 R8
			acc_rd <= req_rd;
		end else if (state == PPMS_D_BUSY && port_edge) begin
			edge_cnt <= edge_cnt + 4'h1;
		end
	end

	// Register array; open bits keep what was written
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			for (int i = 0; i < MAP_SIZE; i++) begin
				mem[i] <= (8'(i) == CAC_ADDR) ? CAC_RESET : 8'h00;
			end
		end else if (do_access && !acc_rd) begin
			if (writable(acc_addr)) begin
				mem[acc_addr] <= acc_data[7:0]; // R2 R8
			end
			if (wide && writable(hi_addr)) begin
				mem[hi_addr] <= acc_data[15:8]; // R3
			end
		end
	end

	// Pin drivers: ready low during access, acknowledge low after it
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			link.ack_oe <= 1'b0;
		end else if (s_mode) begin
			link.ack_oe <= (next_state == PPMS_D_DONE); // R14 R15 R16
		end else begin
			link.ack_oe <= (next_state == PPMS_D_BUSY) | (next_state == PPMS_D_HANG); // R9 R10 R21
		end
	end

	// Read data is put out together with the completion signal
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			link.dev_d <= 16'h0000;
			link.dev_d_oe <= 1'b0;
		end else begin
			if (do_access && acc_rd) begin
				link.dev_d <= {wide ? rd_byte(hi_addr) : 8'h00, rd_byte(acc_addr)}; // R12 R16
			end
			link.dev_d_oe <= acc_rd & (next_state == PPMS_D_DONE); // R8 R20
		end
	end

	// Core notice of each completed write
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			reg_wr_o <= 1'b0;
			reg_addr_o <= 8'h00;
			reg_wdata_o <= 16'h0000;
			bus_wide_o <= 1'b0;
		end else begin
			reg_wr_o <= do_access & ~acc_rd;
			if (do_access && !acc_rd) begin
				reg_addr_o <= acc_addr;
				reg_wdata_o <= acc_data;
			end
			bus_wide_o <= wide;
		end
	end
endmodule : ppms_device

/* File: core/ppms_host.sv */
/*
 * Host end of the parallel port: makes the port clock by a divider and
 * runs one register access per command from a small register set.
 * Assumes the device map in ppms_pkg and pull-ups on the link.
 */
`timescale 1ns/100ps
module ppms_host #(
	parameter int PORT_HALF = ppms_pkg::PORT_HALF_CYC,
	parameter int TIMEOUT_CYCLES = ppms_pkg::TIMEOUT_CYC
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	// Link
	ppms_link_if.host link,
	// Protocol strap, 1 = combined strobes
	input wire logic strobe_mode_i,
	// Register port
	input wire logic [2:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [15:0] reg_rdata_o
);
	import ppms_pkg::*;

	if (PORT_HALF < PORT_HALF_MIN || PORT_HALF > 255 || TIMEOUT_CYCLES < 1
		|| TIMEOUT_CYCLES > 65535) begin : g_bad_param
		$error("PORT_HALF or TIMEOUT_CYCLES out of range");
	end

	logic [7:0] div_cnt;
	logic tick;
	logic [16:0] meta;
	logic [16:0] sync;
	logic s_ack_n;
	logic [15:0] s_data;
	logic [7:0] addr_r;
	logic [15:0] wdata_r;
	logic [15:0] rdata_r;
	logic cmd_rd;
	logic busy;
	logic done;
	logic timed_out;
	logic seen_low;
	logic [15:0] wait_cnt;
	logic finish;
	logic expire;
	ppms_host_state_t state;

	// Port clock runs free; pins move only as it falls
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			div_cnt <= 8'h00;
			link.host_port_clock <= 1'b0;
		end else if (div_cnt == 8'(PORT_HALF - 1)) begin
			div_cnt <= 8'h00;
			link.host_port_clock <= ~link.host_port_clock; // R4
		end else begin
			div_cnt <= div_cnt + 8'h01;
		end
	end

	assign tick = (div_cnt == 8'(PORT_HALF - 1)) & link.host_port_clock;

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			meta <= '1;
			sync <= '1;
		end else begin
			meta <= {link.transfer_ack_n, link.data};
			sync <= meta;
		end
	end

	assign {s_ack_n, s_data} = sync;
	// Split: ready seen low then high again; combined: acknowledge low
	assign finish = strobe_mode_i ? ~s_ack_n : (seen_low & s_ack_n); // R11 R12 R15 R16
	assign expire = (wait_cnt == 16'(TIMEOUT_CYCLES - 1));

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			seen_low <= 1'b0;
			wait_cnt <= 16'h0000;
		end else if (state == PPMS_H_WAIT) begin
			seen_low <= seen_low | ~s_ack_n;
			if (!expire) begin
				wait_cnt <= wait_cnt + 16'h0001;
			end
		end else begin
			seen_low <= 1'b0;
			wait_cnt <= 16'h0000;
		end
	end

	// Access sequencer; a hung device ends in a timeout, not a stuck host
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state <= PPMS_H_IDLE;
			link.cs_n <= 1'b1;
			link.strobe_a_n <= 1'b1;
			link.strobe_b_n <= 1'b1;
			link.addr <= 8'h00;
			link.host_d <= 16'h0000;
			link.host_d_oe <= 1'b0;
			rdata_r <= 16'h0000;
			busy <= 1'b0;
			done <= 1'b0;
			timed_out <= 1'b0;
		end else begin
			if (reg_wr_i && reg_addr_i == H_CMD && reg_wdata_i[CMD_GO] && !busy) begin
				busy <= 1'b1;
				done <= 1'b0;
				timed_out <= 1'b0;
			end
			case (state)
				PPMS_H_IDLE: begin
					if (busy && tick) begin
						link.addr <= addr_r; // R8
						link.host_d <= wdata_r;
						link.host_d_oe <= ~cmd_rd; // R8
						link.strobe_a_n <= strobe_mode_i ? cmd_rd : cmd_rd; // R7 R13
						link.strobe_b_n <= strobe_mode_i ? 1'b0 : ~cmd_rd; // R7 R13
						state <= PPMS_H_SETUP;
					end
				end
				PPMS_H_SETUP: begin
					if (tick) begin
						link.cs_n <= 1'b0; // R11 R15
						state <= PPMS_H_SELECT;
					end
				end
				PPMS_H_SELECT: begin
					if (tick) begin
						state <= PPMS_H_WAIT;
					end
				end
				PPMS_H_WAIT: begin
					if (finish || expire) begin
						rdata_r <= s_data; // R12 R16
						timed_out <= ~finish; // R10
						state <= PPMS_H_END;
					end
				end
				PPMS_H_END: begin
					if (tick) begin
						link.cs_n <= 1'b1; // R11
						link.strobe_a_n <= 1'b1;
						link.strobe_b_n <= 1'b1;
						link.host_d_oe <= 1'b0;
						state <= PPMS_H_RELEASE;
					end
				end
				PPMS_H_RELEASE: begin
					if (tick && (s_ack_n || timed_out)) begin
						busy <= 1'b0;
						done <= 1'b1;
						state <= PPMS_H_IDLE;
					end
				end
				default: state <= PPMS_H_IDLE;
			endcase
		end
	end

	// Software registers
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			addr_r <= 8'h00;
			wdata_r <= 16'h0000;
			cmd_rd <= 1'b0;
			reg_rdata_o <= 16'h0000;
		end else begin
			if (reg_wr_i && !busy) begin
				case (reg_addr_i)
					H_ADDR: addr_r <= reg_wdata_i[7:0];
					H_WDATA: wdata_r <= reg_wdata_i;
					H_CMD: cmd_rd <= reg_wdata_i[CMD_READ];
					default: ;
				endcase
			end
			if (reg_rd_i) begin
				case (reg_addr_i)
					H_ADDR: reg_rdata_o <= {8'h00, addr_r};
					H_WDATA: reg_rdata_o <= wdata_r;
					H_STATUS: reg_rdata_o <= {13'h0000, timed_out, done, busy};
					H_RDATA: reg_rdata_o <= rdata_r;
					default: reg_rdata_o <= 16'h0000;
				endcase
			end
		end
	end
endmodule : ppms_host

/* File: test/ppms_link_asserts.sv */
/*
 * Checker for the link pins between host and device ends.
 * Assumes a port clock half period of 4 ref cycles and a host timeout of 200.
 */
`timescale 1ns/100ps
module ppms_link_asserts (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	// Link pins
	input wire logic host_port_clock,
	input wire logic cs_n,
	input wire logic strobe_a_n,
	input wire logic strobe_b_n,
	input wire logic [7:0] addr,
	input wire logic host_d_oe,
	input wire logic dev_d_oe,
	input wire logic ack_oe
);
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (sys_rst_i);

	bus_contention_a: assert property (!(dev_d_oe && host_d_oe))
		else $error("both ends drive the data bus");
	read_drive_a: assert property ($rose(dev_d_oe) |-> !cs_n && !host_d_oe)
		else $error("device drives data outside a selected read");
	ack_select_a: assert property ($rose(ack_oe) |-> !cs_n)
		else $error("ready or acknowledge pulled without chip select");
	release_idle_a: assert property ($rose(cs_n) |-> ##[0:16] (!ack_oe && !dev_d_oe))
		else $error("pins not released after chip select rose");
	ready_bound_a: assert property ($rose(ack_oe) |-> ##[1:400] !ack_oe)
		else $error("ready or acknowledge held too long");
	strobe_first_a: assert property ($fell(cs_n) |-> !$past(strobe_a_n) || !$past(strobe_b_n))
		else $error("chip select fell before a strobe");
	hold_access_a: assert property (!cs_n && !$past(cs_n) |->
		$stable(addr) && $stable(strobe_a_n) && $stable(strobe_b_n))
		else $error("host changed address or strobes mid access");
	read_data_a: assert property ($fell(ack_oe) && !cs_n && !strobe_b_n |-> dev_d_oe)
		else $error("ready rose without read data");
	port_high_a: assert property ($rose(host_port_clock) |=> host_port_clock [*3])
		else $error("port clock high phase too short");
endmodule : ppms_link_asserts

/* File: test/tb.sv */
/*
 * Testbench: both ends joined by the link, driven through the host register port
 * and compared with a byte-array model of the device map.
 * Assumes the package register layout and a short host timeout.
 */
`timescale 1ns/100ps
module tb;
	import ppms_pkg::*;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic mode = 1'b0;
	logic strap = 1'b0;
	logic [3:0] pins = 4'h0;
	logic [15:0] wi = 16'h0000;
	logic [15:0] wq = 16'h0000;
	logic [15:0] ws = 16'h0000;
	logic [2:0] raddr = 3'h0;
	logic [15:0] rwdata = 16'h0000;
	logic rwr = 1'b0;
	logic rrd = 1'b0;
	logic [15:0] rdata;
	logic bus_wide;
	logic reg_wr;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata;
	logic [15:0] st;
	logic [15:0] rv;
	logic [15:0] d;
	logic [7:0] a;
	logic [3:0] id;
	int failures = 0;
	int total_checks = 0;
	int wr_seen = 0;
	int wr_exp = 0;
	int drv = 0;
	int n0;
	int unsigned rs;
	int mem [256];

	ppms_link_if link ();
	ppms_device #(.ACCESS_EDGES(2)) ppms_device_i (.ref_clk_i(ref_clk), .sys_rst_i(sys_rst),
		.link(link), .port_select_strap_i(strap), .strobe_mode_i(mode),
		.board_id_pins_i(pins), .i_word_i(wi), .q_word_i(wq), .signal_strength_word_i(ws),
		.reg_wr_o(reg_wr), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata),
		.bus_wide_o(bus_wide));
	ppms_host #(.PORT_HALF(4), .TIMEOUT_CYCLES(200)) ppms_host_i (.ref_clk_i(ref_clk),
		.sys_rst_i(sys_rst), .link(link), .strobe_mode_i(mode), .reg_addr_i(raddr),
		.reg_wdata_i(rwdata), .reg_wr_i(rwr), .reg_rd_i(rrd), .reg_rdata_o(rdata));
	ppms_link_asserts ppms_link_asserts_i (.ref_clk_i(ref_clk), .sys_rst_i(sys_rst),
		.host_port_clock(link.host_port_clock), .cs_n(link.cs_n),
		.strobe_a_n(link.strobe_a_n), .strobe_b_n(link.strobe_b_n), .addr(link.addr),
		.host_d_oe(link.host_d_oe), .dev_d_oe(link.dev_d_oe), .ack_oe(link.ack_oe));

	always #20 ref_clk = ~ref_clk;

	// Sampled mid-cycle so a one-cycle pulse counts exactly once
	always @(negedge ref_clk) begin
		if (reg_wr === 1'b1) begin
			wr_seen++;
		end
		if (link.ack_oe !== 1'b0 || link.dev_d_oe !== 1'b0) begin
			drv++;
		end
	end

	task automatic summarize;
		if (failures == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : summarize

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Core write notice; width in force is the one before the write lands
	task automatic wchk(input logic [7:0] x, input logic [15:0] wd);
		wr_exp++;
		chk("reg_addr", {8'h00, x}, {8'h00, reg_addr});
		chk("reg_wdata", mem[CAC_ADDR][CAC_WIDE_BIT] ? wd : {8'h00, wd[7:0]}, reg_wdata);
		chk("reg_wr_count", 16'(wr_exp), 16'(wr_seen));
	endtask : wchk

	task automatic hwr(input logic [2:0] ra, input logic [15:0] wd);
		@(posedge ref_clk);
		raddr <= ra;
		rwdata <= wd;
		rwr <= 1'b1;
		@(posedge ref_clk);
		rwr <= 1'b0;
	endtask : hwr

	task automatic hrd(input logic [2:0] ra, output logic [15:0] q);
		@(posedge ref_clk);
		raddr <= ra;
		rrd <= 1'b1;
		@(posedge ref_clk);
		rrd <= 1'b0;
		#1 q = rdata;
	endtask : hrd

	// One link access; bounded poll so a hung bus cannot stall the run
	task automatic acc(input logic rd, input logic [7:0] ad, input logic [15:0] wd);
		int n;
		n = 0;
		hwr(H_ADDR, {8'h00, ad});
		hwr(H_WDATA, wd);
		hwr(H_CMD, {14'h0000, rd, 1'b1});
		st = 16'h0001;
		while (st[ST_BUSY] !== 1'b0 && n < 600) begin
			hrd(H_STATUS, st);
			n++;
		end
		if (st[ST_BUSY] !== 1'b0) begin
			failures++;
			summarize();
		end
		hrd(H_RDATA, rv);
	endtask : acc

	function automatic logic [7:0] mb(input int x);
		logic [47:0] w3;
		w3 = {ws, wq, wi};
		if (x >= 32'hE8) begin
			return 8'h00;
		end
		if (x >= 32'hE2) begin
			return w3[(x - 32'hE2) * 8 +: 8];
		end
		return 8'(mem[x]);
	endfunction : mb

	function automatic logic [15:0] rexp(input int x);
		return {mem[2][4] ? mb(x + 1) : 8'h00, mb(x)};
	endfunction : rexp

	// Width in force is the one before the write lands
	function automatic void mwr(input int x, input logic [15:0] wd);
		logic w;
		w = mem[2][4];
		if (x < 32'hE2) begin
			mem[x] = wd[7:0];
			if (w && x + 1 < 32'hE2) begin
				mem[x + 1] = wd[15:8];
			end
		end
	endfunction : mwr

	initial begin
		rs = $urandom(32'hE7C1);
		for (int m = 0; m < 2; m++) begin
			@(posedge ref_clk);
			sys_rst <= 1'b1;
			mode <= m[0];
			id = 4'($urandom);
			pins <= id;
			wi <= 16'($urandom);
			wq <= 16'($urandom);
			ws <= 16'($urandom);
			repeat (8) @(posedge ref_clk);
			sys_rst <= 1'b0;
			foreach (mem[k]) mem[k] = 0;
			hrd(3'h7, rv);
			chk("host_unmapped", 16'h0000, rv);
			acc(1'b0, CAC_ADDR, {12'h000, id});
			wchk(CAC_ADDR, {12'h000, id});
			mwr(2, {12'h000, id});
			chk("status", 16'h0002, st);
			hrd(H_ADDR, rv);
			chk("host_addr", {8'h00, CAC_ADDR}, rv);
			hrd(H_WDATA, rv);
			chk("host_wdata", {12'h000, id}, rv);
			repeat (3) begin
				a = 8'(3 + $urandom % 223);
				d = 16'($urandom);
				acc(1'b0, a, d);
				wchk(a, d);
				mwr(a, d);
				chk("status", 16'h0002, st);
				acc(1'b1, a, 16'h0000);
				chk("rdata", rexp(a), rv);
			end
			@(posedge ref_clk);
			pins <= ~id;
			n0 = drv;
			acc(1'b0, a, ~d);
			chk("status", 16'h0006, st);
			chk("ignored_drive", 16'h0000, 16'(drv - n0));
			@(posedge ref_clk);
			pins <= id;
			strap <= 1'b1;
			n0 = drv;
			acc(1'b0, a, d ^ 16'h00FF);
			chk("status", 16'h0006, st);
			chk("ignored_drive", 16'h0000, 16'(drv - n0));
			@(posedge ref_clk);
			strap <= 1'b0;
			acc(1'b1, a, 16'h0000);
			chk("ignored_wr", rexp(a), rv);
			acc(1'b1, 8'(32'hE8 + $urandom % 24), 16'h0000);
			chk("status", 16'h0006, st);
			chk("hang_float", 16'hFFFF, rv);
			acc(1'b0, CAC_ADDR, {11'h000, 1'b1, id});
			wchk(CAC_ADDR, {11'h000, 1'b1, id});
			mwr(2, {11'h000, 1'b1, id});
			chk("bus_wide", 16'h0001, {15'h0000, bus_wide});
			acc(1'b0, a, ~d);
			wchk(a, ~d);
			mwr(a, ~d);
			acc(1'b1, a, 16'h0000);
			chk("rdata_wide", rexp(a), rv);
			for (int k = 0; k < 3; k++) begin
				acc(1'b1, 8'(32'hE2 + 2 * k), 16'h0000);
				chk("out_word", rexp(32'hE2 + 2 * k), rv);
			end
			acc(1'b0, OUT_I_ADDR, ~wi);
			wchk(OUT_I_ADDR, ~wi);
			acc(1'b1, OUT_I_ADDR, 16'h0000);
			chk("out_word_ro", rexp(32'hE2), rv);
		end
		summarize();
	end
endmodule : tb
